// ===== src/occ_pkg.sv
// package: register map, field layout, modes and port types for the compare channel
package occ_pkg;

	// register word indices on the plain register port
	localparam logic [2:0] OCC_ADDR_CTRL    = 3'h0;
	localparam logic [2:0] OCC_ADDR_PRIMARY = 3'h1;
	localparam logic [2:0] OCC_ADDR_SECOND  = 3'h2;
	localparam logic [2:0] OCC_ADDR_STATUS  = 3'h3;
	localparam logic [2:0] OCC_ADDR_CLEAR   = 3'h4;
	localparam logic [2:0] OCC_ADDR_ENABLE  = 3'h5;

	// control register field positions
	localparam int OCC_BIT_IDLE  = 13;
	localparam int OCC_BIT_FLT   = 4;
	localparam int OCC_BIT_TSEL  = 3;
	localparam int OCC_MODE_LSB  = 0;

	localparam logic [15:0] OCC_ZERO16 = 16'h0000;
	localparam logic [1:0]  OCC_IRQ_NONE = 2'h0;

	// status bit positions
	localparam int OCC_ST_MATCH = 0;
	localparam int OCC_ST_FAULT = 1;

	typedef enum logic [2:0] {
		OCC_MODE_OFF    = 3'h0,
		OCC_MODE_OS_LO  = 3'h1,
		OCC_MODE_OS_HI  = 3'h2,
		OCC_MODE_TOGGLE = 3'h3,
		OCC_MODE_DLY_OS = 3'h4,
		OCC_MODE_CONT   = 3'h5,
		OCC_MODE_PWM    = 3'h6,
		OCC_MODE_PWM_F  = 3'h7
	} occ_mode_t;

	// register port request
	typedef struct packed {
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} occ_req_t;

	// fault input synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} occ_sync_t;

endpackage : occ_pkg

// ===== src/occ_sync.sv
// two-flop synchroniser with a falling-edge detector for the fault input
`timescale 1ns/1ps
module occ_sync
	import occ_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic resetn,
	// asynchronous pin in, synchronised level and falling edge out
	input  wire logic pin_in,
	output      logic level,
	output      logic fall
);
	occ_sync_t st_ff;
	occ_sync_t nxt_st;

	// s1 feeds only s2; the edge detector looks at s2 and s3
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = pin_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
	end

	// reset to idle-high, so a pin held low at release reads as one edge
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level = st_ff.s2;
	assign fall  = st_ff.s3 & ~st_ff.s2;

endmodule : occ_sync

// ===== src/occ_channel.sv
// output compare channel: control register, compare engine, fault and irq
// Operation
// - idle-stop bit 1 halts channel during cpu idle; 0 keeps it running.
// - hardware sets pwm fault flag on a fault; 0 means no fault.
// - pwm fault flag is read-only; its write bit is ignored, but a write leaving mode 111 clears it.
// - fault flag is used only in mode 111, pwm with fault input.
// - a readable, writable stop-in-idle bit exists in the control register.
// - mode 000 disables the channel; port register controls the pin.
// - mode 110 raises no interrupt; output starts 0 if compare zero, else 1.
// - mode 111 interrupts on fault falling edge; same initial output rule.
`timescale 1ns/1ps
module occ_channel
	import occ_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// register port
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output      logic [15:0] reg_rdata,
	// system state and timebases
	input  wire logic        cpu_idle,
	input  wire logic [15:0] second_general_timer,
	input  wire logic [15:0] third_general_timer,
	input  wire logic        gpio_out,
	// pins
	input  wire logic        fault_input_a,
	output      logic        compare_output_pin,
	// interrupt
	output      logic        irq
);

	typedef struct packed {
		logic        idle_stop_select;
		logic        pwm_fault_flag;
		logic        timebase_select;
		logic [2:0]  compare_mode_field;
		logic [15:0] primary_compare_value;
		logic [15:0] second_compare_value;
		logic [15:0] last_timer;
		logic        out;
		logic        fired;
		logic [1:0]  status;
		logic [1:0]  irq_en;
		logic [15:0] rdata;
	} occ_state_t;

	occ_state_t st_ff;
	occ_state_t nxt_st;
	occ_req_t   req;
	logic       flt_level;
	logic       flt_fall;
	logic [15:0] tb;
	logic       running;
	logic       wrap;
	logic       hit_pri;
	logic       hit_sec;
	logic [1:0] ev;
	occ_mode_t  mode;

	// initial pin state of the pwm modes from the primary compare value
	function automatic logic pwm_init(input logic [15:0] pri);
		pwm_init = (pri != OCC_ZERO16);
	endfunction : pwm_init

	// control register image as software reads it
	function automatic logic [15:0] ctrl_word(input occ_state_t s);
		ctrl_word = OCC_ZERO16;
		ctrl_word[OCC_BIT_IDLE] = s.idle_stop_select;
		ctrl_word[OCC_BIT_FLT]  = s.pwm_fault_flag;
		ctrl_word[OCC_BIT_TSEL] = s.timebase_select;
		ctrl_word[OCC_MODE_LSB +: 3] = s.compare_mode_field;
	endfunction : ctrl_word

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	occ_sync u_flt (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin_in   (fault_input_a),
		.level    (flt_level),
		.fall     (flt_fall)
	);

	// timebase choice and compare events
	assign tb      = st_ff.timebase_select ? third_general_timer
	                                       : second_general_timer;
	assign mode    = occ_mode_t'(st_ff.compare_mode_field);
	assign running = (mode != OCC_MODE_OFF)
	               && !(cpu_idle && st_ff.idle_stop_select);
	assign wrap    = tb < st_ff.last_timer;
	assign hit_pri = (tb == st_ff.primary_compare_value)
	               && (st_ff.last_timer != tb);
	assign hit_sec = (tb == st_ff.second_compare_value)
	               && (st_ff.last_timer != tb);

	// next-state logic: register writes, compare engine, fault and status
	always_comb begin
		nxt_st = st_ff;
		ev     = OCC_IRQ_NONE;
		nxt_st.rdata = OCC_ZERO16;
		nxt_st.last_timer = tb;

		// compare engine runs only while enabled and not idle-stopped
		if (running) begin
			case (mode)
			OCC_MODE_OS_LO: begin
				if (hit_pri && !st_ff.fired) begin
					nxt_st.out   = 1'b1;
					nxt_st.fired = 1'b1;
					ev[OCC_ST_MATCH] = 1'b1;
				end
			end
			OCC_MODE_OS_HI: begin
				if (hit_pri && !st_ff.fired) begin
					nxt_st.out   = 1'b0;
					nxt_st.fired = 1'b1;
					ev[OCC_ST_MATCH] = 1'b1;
				end
			end
			OCC_MODE_TOGGLE: begin
				if (hit_pri) begin
					nxt_st.out = ~st_ff.out;
					ev[OCC_ST_MATCH] = 1'b1;
				end
			end
			OCC_MODE_DLY_OS, OCC_MODE_CONT: begin
				if (hit_pri && !st_ff.fired) begin
					nxt_st.out = 1'b1;
				end
				if (hit_sec && st_ff.out) begin
					nxt_st.out = 1'b0;
					nxt_st.fired = (mode == OCC_MODE_DLY_OS);
					ev[OCC_ST_MATCH] = 1'b1;
				end
			end
			OCC_MODE_PWM, OCC_MODE_PWM_F: begin
				// no compare interrupt in either pwm mode
				if (wrap) begin
					nxt_st.out = pwm_init(st_ff.primary_compare_value);
				end else if (hit_pri) begin
					nxt_st.out = 1'b0;
				end
				if (mode == OCC_MODE_PWM_F) begin
					if (flt_fall) begin
						nxt_st.pwm_fault_flag = 1'b1;
						ev[OCC_ST_FAULT] = 1'b1;
					end
					if (st_ff.pwm_fault_flag || flt_fall) begin
						nxt_st.out = 1'b0;
					end
				end
			end
			default: begin
				nxt_st.out = st_ff.out;
			end
			endcase
		end

		// hardware clears the fault flag at a timer wrap once the pin is high again in mode 111
		if (mode == OCC_MODE_PWM_F && flt_level && !flt_fall && wrap) begin
			nxt_st.pwm_fault_flag = 1'b0;
		end
		if (mode != OCC_MODE_PWM_F) begin
			nxt_st.pwm_fault_flag = 1'b0;
		end

		// register writes; the fault flag bit of the write is ignored
		if (req.wr) begin
			case (req.addr)
			OCC_ADDR_CTRL: begin
				nxt_st.idle_stop_select   = req.wdata[OCC_BIT_IDLE];
				nxt_st.timebase_select    = req.wdata[OCC_BIT_TSEL];
				nxt_st.compare_mode_field = req.wdata[OCC_MODE_LSB +: 3];
				nxt_st.fired = 1'b0;
				// load the documented initial pin state for the new mode
				case (occ_mode_t'(req.wdata[OCC_MODE_LSB +: 3]))
				OCC_MODE_OS_HI: nxt_st.out = 1'b1;
				OCC_MODE_TOGGLE: nxt_st.out = st_ff.out;
				OCC_MODE_PWM, OCC_MODE_PWM_F: begin
					nxt_st.out = pwm_init(st_ff.primary_compare_value);
				end
				default: nxt_st.out = 1'b0;
				endcase
			end
			OCC_ADDR_PRIMARY: nxt_st.primary_compare_value = req.wdata;
			OCC_ADDR_SECOND:  nxt_st.second_compare_value  = req.wdata;
			OCC_ADDR_CLEAR: begin
				nxt_st.status = st_ff.status & ~req.wdata[1:0];
			end
			OCC_ADDR_ENABLE: nxt_st.irq_en = req.wdata[1:0];
			default: begin
				nxt_st.irq_en = nxt_st.irq_en;
			end
			endcase
		end

		// a new event wins over a clear in the same cycle
		nxt_st.status = nxt_st.status | ev;

		// read data valid in the cycle after the strobe only
		if (req.rd) begin
			case (req.addr)
			OCC_ADDR_CTRL:    nxt_st.rdata = ctrl_word(st_ff);
			OCC_ADDR_PRIMARY: nxt_st.rdata = st_ff.primary_compare_value;
			OCC_ADDR_SECOND:  nxt_st.rdata = st_ff.second_compare_value;
			OCC_ADDR_STATUS:  nxt_st.rdata = {14'h0000, st_ff.status};
			OCC_ADDR_ENABLE:  nxt_st.rdata = {14'h0000, st_ff.irq_en};
			default:          nxt_st.rdata = OCC_ZERO16;
			endcase
		end
	end

	// all state resets to a disabled channel with out low; the pin follows gpio_out
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// pin is the port register's in mode 000, otherwise the channel's
	assign compare_output_pin = (mode == OCC_MODE_OFF) ? gpio_out
	                                                   : st_ff.out;
	assign reg_rdata = st_ff.rdata;
	assign irq       = |(st_ff.status & st_ff.irq_en);

	// a fault edge in mode 111 while running sets flag and status next cycle
	chk_fault_sets: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(flt_fall && running && mode == OCC_MODE_PWM_F)
		|=> (st_ff.pwm_fault_flag && st_ff.status[OCC_ST_FAULT]))
		else $error("fault edge did not set the fault flag");

	// a write alone never raises the fault flag
	chk_flag_readonly: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(req.wr && req.addr == OCC_ADDR_CTRL && !st_ff.pwm_fault_flag
		 && !flt_fall) |=> !st_ff.pwm_fault_flag)
		else $error("software write set the fault flag");

	// flag stays clear outside mode 111
	chk_flag_mode: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(mode != OCC_MODE_PWM_F) |=> (mode == OCC_MODE_PWM_F
		 || !st_ff.pwm_fault_flag))
		else $error("fault flag set outside fault pwm mode");

	// halted while idle with the stop bit: the pin holds
	chk_idle_halt: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(cpu_idle && st_ff.idle_stop_select && !req.wr
		 && mode != OCC_MODE_OFF) |=> $stable(st_ff.out))
		else $error("channel moved while stopped in idle");

	// stop bit reads back what was written, with one idle cycle between
	chk_idle_rw: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(req.wr && req.addr == OCC_ADDR_CTRL) ##1 !req.wr
		##1 (req.rd && req.addr == OCC_ADDR_CTRL && !req.wr)
		|=> reg_rdata[OCC_BIT_IDLE] == $past(req.wdata[OCC_BIT_IDLE], 3))
		else $error("stop bit readback mismatch");

	// mode 000 passes the port register through
	chk_off_gpio: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(mode == OCC_MODE_OFF) |-> compare_output_pin == gpio_out)
		else $error("pin not under port control in mode 000");

	// pwm without fault never raises a status bit
	chk_pwm_noirq: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(mode == OCC_MODE_PWM && st_ff.status == OCC_IRQ_NONE && !req.wr)
		|=> st_ff.status == OCC_IRQ_NONE)
		else $error("interrupt event in mode 110");

	// entering pwm mode 111 loads the zero or non-zero initial state
	chk_pwm_init: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(req.wr && req.addr == OCC_ADDR_CTRL
		 && req.wdata[OCC_MODE_LSB +: 3] == OCC_MODE_PWM_F)
		|=> st_ff.out == pwm_init($past(st_ff.primary_compare_value)))
		else $error("wrong pwm initial pin state");

	// a moving unselected timer never moves the pwm pin
	chk_tsel: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(running && mode == OCC_MODE_PWM && !req.wr
		 && $stable(st_ff.timebase_select)
		 && (st_ff.timebase_select ? $stable(third_general_timer)
		                           : $stable(second_general_timer)))
		|=> $stable(st_ff.out))
		else $error("unselected timebase moved the pin");

	// the fault status bit is sticky until software clears it
	chk_status_sticky: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(st_ff.status[OCC_ST_FAULT]
		 && !(req.wr && req.addr == OCC_ADDR_CLEAR
		 && req.wdata[OCC_ST_FAULT])) |=> st_ff.status[OCC_ST_FAULT])
		else $error("fault status bit lost without a clear");

	// read data stand one cycle only and read zero otherwise
	chk_rdata_one_cycle: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!req.rd |=> reg_rdata == OCC_ZERO16)
		else $error("read data outside the read answer cycle");

	// a latched fault holds the pin low while the channel runs
	chk_fault_pin_low: assert property (
		@(posedge core_clk) disable iff (!resetn)
		(running && mode == OCC_MODE_PWM_F && st_ff.pwm_fault_flag
		 && !req.wr) |=> !compare_output_pin)
		else $error("pin high while a fault is latched");

endmodule : occ_channel

// ===== test/occ_far_side.sv
// far side model: two timebase counters and the fault pin of the channel
`timescale 1ns/1ps
module occ_far_side
	import occ_pkg::*;
#(
	parameter logic [15:0] PER2 = 16'h0010,
	parameter logic [15:0] PER3 = 16'h0018
)(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// run enables and fault request from the bench
	input  wire logic        run_second,
	input  wire logic        run_third,
	input  wire logic        fault_req,
	// timer counts and fault pin
	output      logic [15:0] second_general_timer,
	output      logic [15:0] third_general_timer,
	output      logic        fault_input_a
);
	logic [15:0] cnt2_ff;
	logic [15:0] cnt3_ff;

	// a stopped timer holds its count, so control writes meet a still base
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt2_ff <= 16'h0000;
			cnt3_ff <= 16'h0000;
		end else begin
			if (run_second)
				cnt2_ff <= (cnt2_ff == PER2 - 16'h0001) ? 16'h0000
				                                        : cnt2_ff + 16'h0001;
			if (run_third)
				cnt3_ff <= (cnt3_ff == PER3 - 16'h0001) ? 16'h0000
				                                        : cnt3_ff + 16'h0001;
		end
	end

	// fault pin is active low and rests high outside a fault
	assign second_general_timer = cnt2_ff;
	assign third_general_timer  = cnt3_ff;
	assign fault_input_a        = ~fault_req;
endmodule : occ_far_side

// ===== test/tb_occ_channel.sv
// testbench of the compare channel, results checked against a note queue
`timescale 1ns/1ps
module tb_occ_channel import occ_pkg::*;;
	logic        core_clk, resetn, reg_wr, reg_rd, cpu_idle, gpio_out;
	logic        fault_input_a, compare_output_pin, irq;
	logic        run2, run3, flt, look_req, rd_seen;
	logic [2:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, p;
	logic [15:0] second_general_timer, third_general_timer;
	logic [15:0] q[$];
	int          fails, checks, seed, i;

	occ_channel dut (.core_clk(core_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle),
		.second_general_timer(second_general_timer),
		.third_general_timer(third_general_timer), .gpio_out(gpio_out),
		.fault_input_a(fault_input_a),
		.compare_output_pin(compare_output_pin), .irq(irq));
	occ_far_side far (.core_clk(core_clk), .resetn(resetn),
		.run_second(run2), .run_third(run3), .fault_req(flt),
		.second_general_timer(second_general_timer),
		.third_general_timer(third_general_timer),
		.fault_input_a(fault_input_a));

	task cmp(input logic [15:0] got);
		logic [15:0] e;
		e = q.pop_front();
		checks++;
		if (got !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, e);
		end
	endtask : cmp

	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge core_clk);
		q.push_back(e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask : rd

	// two edges of settling first: the pin is loaded after the write lands
	task look(input logic [15:0] e);
		repeat (2) @(posedge core_clk);
		q.push_back(e);
		look_req <= 1'b1;
		@(posedge core_clk);
		look_req <= 1'b0;
	endtask : look

	// fault held long enough to pass the two-flop synchroniser
	task pulse;
		@(posedge core_clk);
		flt <= 1'b1;
		repeat (4) @(posedge core_clk);
		flt <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : pulse

	task end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	// read data stand the cycle after the strobe, a look in the cycle of its own request
	always @(posedge core_clk) begin
		if (rd_seen)
			cmp(reg_rdata);
		if (look_req)
			cmp({14'h0000, irq, compare_output_pin});
		rd_seen <= reg_rd;
	end

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		end_of_test;
	end

	initial begin
		{resetn, reg_wr, reg_rd, cpu_idle, gpio_out} = 5'h00;
		{run2, run3, flt, look_req} = 4'h0;
		reg_addr  = 3'h0;
		reg_wdata = 16'h0000;
		seed      = 32'hf4d3;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		// timers stay stopped across every control write below
		rd(OCC_ADDR_CTRL, 16'h0000);
		rd(3'h7, 16'h0000);
		for (i = 0; i < 4; i++) begin
			gpio_out <= 1'($random(seed));
			@(posedge core_clk);
			look({15'h0000, gpio_out});
		end
		$display("test reset and disabled pin done");
		for (i = 0; i < 8; i++) begin
			wr(OCC_ADDR_CTRL, 16'(i));
			rd(OCC_ADDR_CTRL, 16'(i));
		end
		wr(OCC_ADDR_CTRL, 16'hffff);
		rd(OCC_ADDR_CTRL, 16'h200f);
		wr(OCC_ADDR_STATUS, 16'hffff);
		rd(OCC_ADDR_STATUS, 16'h0000);
		p = 16'($random(seed));
		wr(OCC_ADDR_SECOND, p);
		rd(OCC_ADDR_SECOND, p);
		$display("test control access done");
		wr(OCC_ADDR_ENABLE, 16'h0003);
		for (i = 0; i < 2; i++) begin
			p = i ? (16'($random(seed)) | 16'h0001) : 16'h0000;
			wr(OCC_ADDR_PRIMARY, p);
			wr(OCC_ADDR_CTRL, 16'h0006);
			look({15'h0000, p != 16'h0000});
		end
		pulse;
		rd(OCC_ADDR_STATUS, 16'h0000);
		rd(OCC_ADDR_CTRL, 16'h0006);
		$display("test pwm without fault done");
		wr(OCC_ADDR_CTRL, 16'h0007);
		look(16'h0001);
		pulse;
		rd(OCC_ADDR_CTRL, 16'h0017);
		look(16'h0002);
		wr(OCC_ADDR_CTRL, 16'h0007);
		rd(OCC_ADDR_CTRL, 16'h0017);
		wr(OCC_ADDR_CLEAR, 16'h0002);
		rd(OCC_ADDR_STATUS, 16'h0000);
		look(16'h0000);
		$display("test pwm with fault done");
		wr(OCC_ADDR_CTRL, 16'h0000);
		cpu_idle <= 1'b1;
		wr(OCC_ADDR_CTRL, 16'h2007);
		pulse;
		rd(OCC_ADDR_CTRL, 16'h2007);
		wr(OCC_ADDR_CTRL, 16'h0007);
		pulse;
		rd(OCC_ADDR_CTRL, 16'h0017);
		cpu_idle <= 1'b0;
		// the idle test leaves a fault event pending; drop it so irq reads 0
		wr(OCC_ADDR_CLEAR, 16'h0003);
		$display("test idle stop done");
		wr(OCC_ADDR_CTRL, 16'h0000);
		wr(OCC_ADDR_PRIMARY, 16'h0005);
		wr(OCC_ADDR_CTRL, 16'h000e);
		run2 <= 1'b1;
		repeat (60) @(posedge core_clk);
		run2 <= 1'b0;
		look(16'h0001);
		run3 <= 1'b1;
		for (i = 0; i < 200 && third_general_timer !== 16'h0008; i++)
			@(posedge core_clk);
		run3 <= 1'b0;
		look(16'h0000);
		// one-shot on the third timer: pin and irq rise on the same edge at the match
		wr(OCC_ADDR_PRIMARY, 16'h000c);
		wr(OCC_ADDR_CTRL, 16'h0009);
		run3 <= 1'b1;
		for (i = 0; i < 200 && third_general_timer !== 16'h000e; i++)
			@(posedge core_clk);
		run3 <= 1'b0;
		look(16'h0003);
		$display("test timebase select done");
		repeat (4) @(posedge core_clk);
		end_of_test;
	end
endmodule : tb_occ_channel
